// File: verilog/fmt_pkg.sv
// Shared constants, types and helpers for the line format and baud block
package fmt_pkg;

   // ****************************************
   // Register offsets on the 3-bit address
   // ****************************************
   localparam logic [2:0] OFS_DATA = 3'h0;
   localparam logic [2:0] OFS_IER  = 3'h1;
   localparam logic [2:0] OFS_DLL  = 3'h0;
   localparam logic [2:0] OFS_DLM  = 3'h1;
   localparam logic [2:0] OFS_LCR  = 3'h3;
   localparam logic [2:0] OFS_LSR  = 3'h5;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] LCR_RESET = 8'h00;
   localparam logic [7:0] DIV_RESET = 8'h00;
   localparam logic [3:0] IER_RESET = 4'h0;

   // ****************************************
   // Timing counts in 16x ticks
   // ****************************************
   localparam logic [5:0] BIT_TICKS     = 6'h10;
   localparam logic [5:0] STOP_ONE      = 6'h10;
   localparam logic [5:0] STOP_ONE_HALF = 6'h18;
   localparam logic [5:0] STOP_TWO      = 6'h20;
   localparam logic [3:0] MID_TICK      = 4'h7;
   localparam logic [3:0] LAST_TICK     = 4'hF;

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic div_access_sel;
      logic break_ctl;
      logic fixed_parity_select;
      logic even_parity_select;
      logic parity_on;
      logic stop_count_select;
      logic char_length_sel_hi;
      logic char_length_sel_lo;
   } lcr_t;

   typedef struct packed {
      logic       cs;
      logic       wr;
      logic       rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } bus_req_t;

   typedef enum logic [2:0] {
      LS_IDLE  = 3'b000,
      LS_START = 3'b001,
      LS_DATA  = 3'b010,
      LS_PAR   = 3'b011,
      LS_STOP  = 3'b100
   } line_state_t;

   // ****************************************
   // Helpers
   // ****************************************
   // Index of the last data bit: 4 for five bits up to 7 for eight
   function automatic logic [2:0] last_bit(lcr_t f);
      return {1'b1, f.char_length_sel_hi, f.char_length_sel_lo};
   endfunction

   function automatic logic parity_bit(lcr_t f, logic [7:0] d);
      logic [7:0] m;
      m = 8'hFF >> (3'h7 - last_bit(f));
      if (f.fixed_parity_select)
         return ~f.even_parity_select;
      return (^(d & m)) ^ ~f.even_parity_select;
   endfunction

   function automatic logic [5:0] stop_ticks(lcr_t f);
      if (!f.stop_count_select)
         return STOP_ONE;
      if (last_bit(f) == 3'h4)
         return STOP_ONE_HALF;
      return STOP_TWO;
   endfunction

endpackage

// File: verilog/baud_tick_gen.sv
// Programmable divider that makes the 16x oversampling tick
`timescale 1ns/1ps
module baud_tick_gen #(
   parameter int DIV_W = 16
)(
   input  logic             mclk,
   input  logic             rstn,
   input  logic [DIV_W-1:0] divisor,
   input  logic             reload,
   output logic             tick
);

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic             tick;
   } baud_st_t;

   baud_st_t st_q;
   baud_st_t st_d;

   always_comb
   begin
      st_d      = st_q;
      st_d.tick = 1'b0;
      if (reload)
         st_d.cnt = divisor;
      else if (divisor != '0)
      begin
         if (st_q.cnt <= 1)
         begin
            st_d.cnt  = divisor;
            st_d.tick = 1'b1;
         end
         else
            st_d.cnt = st_q.cnt - 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign tick = st_q.tick;

   property p_reload;
      @(posedge mclk) disable iff (!rstn)
      reload |=> st_q.cnt == $past(divisor) && !tick;
   endproperty
   a_reload: assert property (p_reload)
      else $error("divisor write did not reload counter");

   property p_tick_due;
      @(posedge mclk) disable iff (!rstn)
      (st_q.cnt == 1 && divisor != '0 && !reload) |=> tick;
   endproperty
   a_tick_due: assert property (p_tick_due)
      else $error("tick missing at end of count");

   property p_tick_reload;
      @(posedge mclk) disable iff (!rstn)
      tick |-> st_q.cnt == $past(divisor) && divisor != '0;
   endproperty
   a_tick_reload: assert property (p_tick_reload)
      else $error("counter not reloaded with divisor on tick");

endmodule

// File: verilog/tx_serializer.sv
// Transmit holding register and shift register with framing
`timescale 1ns/1ps
module tx_serializer (
   input  logic             mclk,
   input  logic             rstn,
   input  logic             tick,
   input  fmt_pkg::lcr_t    fmt,
   input  logic             load,
   input  logic [7:0]       load_data,
   output logic             line,
   output logic             holding_empty_flag,
   output logic             transmitter_idle_flag
);

   typedef struct packed {
      fmt_pkg::line_state_t state;
      logic [7:0]           hold;
      logic                 hold_full;
      logic [7:0]           shift;
      logic                 par;
      logic [5:0]           tcnt;
      logic [2:0]           bcnt;
      logic                 line_n;
      logic [5:0]           stop_seen;
   } tx_st_t;

   tx_st_t     st_q;
   tx_st_t     st_d;
   logic [5:0] limit;
   logic       done;

   always_comb
   begin
      st_d  = st_q;
      limit = (st_q.state == fmt_pkg::LS_STOP) ?
              fmt_pkg::stop_ticks(fmt) : fmt_pkg::BIT_TICKS;
      done  = tick && (st_q.tcnt == limit - 6'h01);
      if (tick)
         st_d.tcnt = done ? 6'h00 : st_q.tcnt + 6'h01;
      if (tick && st_q.state == fmt_pkg::LS_STOP)
         st_d.stop_seen = st_q.stop_seen + 6'h01;
      case (st_q.state)
         fmt_pkg::LS_IDLE:
            if (st_q.hold_full)
            begin
               st_d.shift     = st_q.hold;
               st_d.par       = fmt_pkg::parity_bit(fmt, st_q.hold);
               st_d.hold_full = 1'b0;
               st_d.tcnt      = 6'h00;
               st_d.bcnt      = 3'h0;
               st_d.state     = fmt_pkg::LS_START;
            end
         fmt_pkg::LS_START:
            if (done)
               st_d.state = fmt_pkg::LS_DATA;
         fmt_pkg::LS_DATA:
            if (done)
            begin
               st_d.shift = st_q.shift >> 1;
               st_d.bcnt  = st_q.bcnt + 3'h1;
               if (st_q.bcnt == fmt_pkg::last_bit(fmt))
               begin
                  st_d.stop_seen = 6'h00;
                  st_d.state     = fmt.parity_on ?
                                   fmt_pkg::LS_PAR : fmt_pkg::LS_STOP;
               end
            end
         fmt_pkg::LS_PAR:
            if (done)
            begin
               st_d.stop_seen = 6'h00;
               st_d.state     = fmt_pkg::LS_STOP;
            end
         fmt_pkg::LS_STOP:
            if (done)
               st_d.state = fmt_pkg::LS_IDLE;
         default:
            st_d.state = fmt_pkg::LS_IDLE;
      endcase
      // A new load in the same cycle as the move into the shift register refills the holding register
      if (load)
      begin
         st_d.hold      = load_data;
         st_d.hold_full = 1'b1;
      end
      case (st_d.state)
         fmt_pkg::LS_START: st_d.line_n = 1'b1;
         fmt_pkg::LS_DATA:  st_d.line_n = ~st_d.shift[0];
         fmt_pkg::LS_PAR:   st_d.line_n = ~st_d.par;
         default:           st_d.line_n = 1'b0;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign line                  = ~st_q.line_n;
   assign holding_empty_flag    = ~st_q.hold_full;
   assign transmitter_idle_flag = ~st_q.hold_full &&
                                  st_q.state == fmt_pkg::LS_IDLE;

   property p_stop_one;
      @(posedge mclk) disable iff (!rstn)
      ($past(st_q.state) == fmt_pkg::LS_STOP &&
       st_q.state != fmt_pkg::LS_STOP && !fmt.stop_count_select)
      |-> st_q.stop_seen == 6'h10;
   endproperty
   a_stop_one: assert property (p_stop_one)
      else $error("single stop bit not 16 ticks");

   property p_stop_half;
      @(posedge mclk) disable iff (!rstn)
      ($past(st_q.state) == fmt_pkg::LS_STOP &&
       st_q.state != fmt_pkg::LS_STOP && fmt.stop_count_select &&
       fmt_pkg::last_bit(fmt) == 3'h4)
      |-> st_q.stop_seen == 6'h18;
   endproperty
   a_stop_half: assert property (p_stop_half)
      else $error("one and a half stop bits not 24 ticks");

   property p_stop_two;
      @(posedge mclk) disable iff (!rstn)
      ($past(st_q.state) == fmt_pkg::LS_STOP &&
       st_q.state != fmt_pkg::LS_STOP && fmt.stop_count_select &&
       fmt_pkg::last_bit(fmt) != 3'h4)
      |-> st_q.stop_seen == 6'h20;
   endproperty
   a_stop_two: assert property (p_stop_two)
      else $error("two stop bits not 32 ticks");

   property p_idle_flag;
      @(posedge mclk) disable iff (!rstn)
      load |=> !transmitter_idle_flag && !holding_empty_flag;
   endproperty
   a_idle_flag: assert property (p_idle_flag)
      else $error("flags show empty with a character held");

endmodule

// File: verilog/uart_line_ctrl.sv
// Line format control, divisor latches, transmitter and receiver channel
`timescale 1ns/1ps
module uart_line_ctrl (
   input  logic              mclk,
   input  logic              rstn,
   input  fmt_pkg::bus_req_t bus,
   output logic [7:0]        rdata,
   input  logic              serial_input,
   output logic              serial_output,
   output logic              holding_empty_flag,
   output logic              transmitter_idle_flag,
   output logic              baud_tick
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      fmt_pkg::lcr_t        line_format_control;
      logic [7:0]           div_lo;
      logic [7:0]           div_hi;
      logic [3:0]           ier;
      logic [7:0]           rbr;
      logic                 dr;
      logic                 oe;
      logic                 pe;
      logic                 fe;
      logic [7:0]           rdata;
      logic                 so_n;
      logic                 sin_meta_n;
      logic                 sin_sync_n;
      fmt_pkg::line_state_t rstate;
      logic [3:0]           rtick;
      logic [2:0]           rbit;
      logic [7:0]           rshift;
      logic                 rpar;
   } ctl_st_t;

   ctl_st_t     st_q;
   ctl_st_t     st_d;
   logic        wr;
   logic        rd;
   logic        divisor_access_select;
   logic        tx_load;
   logic        div_reload;
   logic        tx_line;
   logic        sin;
   logic [7:0]  rx_char;
   logic [15:0] divisor;

   // Next latch value, so a latch write reloads the counter with the new byte
   assign divisor = {st_d.div_hi, st_d.div_lo};

   // ****************************************
   // Baud generator and transmitter
   // ****************************************
   baud_tick_gen #(
      .DIV_W (16)
   ) u_baud (
      .mclk    (mclk),
      .rstn    (rstn),
      .divisor (divisor),
      .reload  (div_reload),
      .tick    (baud_tick)
   );

   tx_serializer u_tx (
      .mclk                  (mclk),
      .rstn                  (rstn),
      .tick                  (baud_tick),
      .fmt                   (st_q.line_format_control),
      .load                  (tx_load),
      .load_data             (bus.wdata),
      .line                  (tx_line),
      .holding_empty_flag    (holding_empty_flag),
      .transmitter_idle_flag (transmitter_idle_flag)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      st_d       = st_q;
      wr         = bus.cs && bus.wr;
      rd         = bus.cs && bus.rd;
      divisor_access_select       = st_q.line_format_control.div_access_sel;
      sin        = ~st_q.sin_sync_n;
      rx_char    = st_q.rshift >> (3'h7 - fmt_pkg::last_bit(st_q.line_format_control));
      tx_load    = wr && bus.addr == fmt_pkg::OFS_DATA && !divisor_access_select;
      div_reload = wr && divisor_access_select && (bus.addr == fmt_pkg::OFS_DLL ||
                                  bus.addr == fmt_pkg::OFS_DLM);

      // Host writes
      if (wr)
      begin
         case (bus.addr)
            fmt_pkg::OFS_DATA:
               if (divisor_access_select)
                  st_d.div_lo = bus.wdata;
            fmt_pkg::OFS_IER:
               if (divisor_access_select)
                  st_d.div_hi = bus.wdata;
               else
                  st_d.ier = bus.wdata[3:0];
            fmt_pkg::OFS_LCR:
               st_d.line_format_control = fmt_pkg::lcr_t'(bus.wdata);
            default:
               st_d.line_format_control = st_q.line_format_control;
         endcase
      end

      // Host reads, with their clearing side effects
      if (rd)
      begin
         case (bus.addr)
            fmt_pkg::OFS_DATA:
               if (divisor_access_select)
                  st_d.rdata = st_q.div_lo;
               else
               begin
                  st_d.rdata = st_q.rbr;
                  st_d.dr    = 1'b0;
               end
            fmt_pkg::OFS_IER:
               st_d.rdata = divisor_access_select ? st_q.div_hi : {4'h0, st_q.ier};
            fmt_pkg::OFS_LCR:
               st_d.rdata = st_q.line_format_control;
            fmt_pkg::OFS_LSR:
            begin
               st_d.rdata = {1'b0, transmitter_idle_flag,
                             holding_empty_flag, 1'b0, st_q.fe,
                             st_q.pe, st_q.oe, st_q.dr};
               st_d.oe    = 1'b0;
               st_d.pe    = 1'b0;
               st_d.fe    = 1'b0;
            end
            default:
               st_d.rdata = 8'h00;
         endcase
      end

      // Serial input synchroniser
      st_d.sin_meta_n = ~serial_input;
      st_d.sin_sync_n = st_q.sin_meta_n;

      // Receiver, sampling mid-bit on the 16x tick
      if (baud_tick)
      begin
         st_d.rtick = st_q.rtick + 4'h1;
         case (st_q.rstate)
            fmt_pkg::LS_IDLE:
               if (!sin)
               begin
                  st_d.rtick  = 4'h0;
                  st_d.rbit   = 3'h0;
                  st_d.rstate = fmt_pkg::LS_START;
               end
            fmt_pkg::LS_START:
               if (st_q.rtick == fmt_pkg::MID_TICK)
               begin
                  st_d.rtick  = 4'h0;
                  st_d.rstate = sin ? fmt_pkg::LS_IDLE :
                                      fmt_pkg::LS_DATA;
               end
            fmt_pkg::LS_DATA:
               if (st_q.rtick == fmt_pkg::LAST_TICK)
               begin
                  st_d.rshift = {sin, st_q.rshift[7:1]};
                  st_d.rbit   = st_q.rbit + 3'h1;
                  if (st_q.rbit == fmt_pkg::last_bit(st_q.line_format_control))
                     st_d.rstate = st_q.line_format_control.parity_on ?
                                   fmt_pkg::LS_PAR : fmt_pkg::LS_STOP;
               end
            fmt_pkg::LS_PAR:
               if (st_q.rtick == fmt_pkg::LAST_TICK)
               begin
                  st_d.rpar   = sin;
                  st_d.rstate = fmt_pkg::LS_STOP;
               end
            fmt_pkg::LS_STOP:
               if (st_q.rtick == fmt_pkg::LAST_TICK)
               begin
                  // Only the first stop bit is looked at; later ones idle
                  st_d.rbr    = rx_char;
                  st_d.oe     = st_d.oe | st_q.dr;
                  st_d.dr     = 1'b1;
                  st_d.fe     = st_d.fe | ~sin;
                  st_d.pe     = st_d.pe | (st_q.line_format_control.parity_on &&
                                st_q.rpar !=
                                fmt_pkg::parity_bit(st_q.line_format_control, rx_char));
                  st_d.rstate = fmt_pkg::LS_IDLE;
               end
            default:
               st_d.rstate = fmt_pkg::LS_IDLE;
         endcase
      end

      // Break acts on the pin only; the transmitter runs on
      st_d.so_n = st_q.line_format_control.break_ctl | ~tx_line;
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         st_q        <= '0;
         st_q.line_format_control    <= fmt_pkg::LCR_RESET;
         st_q.div_lo <= fmt_pkg::DIV_RESET;
         st_q.div_hi <= fmt_pkg::DIV_RESET;
         st_q.ier    <= fmt_pkg::IER_RESET;
      end
      else
         st_q <= st_d;
   end

   assign rdata         = st_q.rdata;
   assign serial_output = ~st_q.so_n;

   // ****************************************
   // Checks
   // ****************************************
   property p_break;
      @(posedge mclk) disable iff (!rstn)
      st_q.line_format_control.break_ctl |=> !serial_output;
   endproperty
   a_break: assert property (p_break)
      else $error("serial output not held low during break");

   property p_lcr_readback;
      @(posedge mclk) disable iff (!rstn)
      (wr && bus.addr == fmt_pkg::OFS_LCR)
      ##2 (rd && bus.addr == fmt_pkg::OFS_LCR)
      |=> rdata == $past(bus.wdata, 3);
   endproperty
   a_lcr_readback: assert property (p_lcr_readback)
      else $error("format register read differs from last write");

   property p_divisor_access_select_route;
      @(posedge mclk) disable iff (!rstn)
      (wr && bus.addr == fmt_pkg::OFS_DLL)
      |=> st_q.div_lo == ($past(divisor_access_select) ? $past(bus.wdata) :
                          $past(st_q.div_lo));
   endproperty
   a_divisor_access_select_route: assert property (p_divisor_access_select_route)
      else $error("divisor latch access routed wrongly");

endmodule

// File: tb/serial_peer.sv
// Remote serial terminal: sends frames and captures frames from the block
`timescale 1ns/1ps
module serial_peer (
   input  wire logic       mclk,
   input  wire logic       tick,
   input  wire logic       line_in,
   input  wire logic [3:0] nsamp,
   output logic            line_out
);
   int unsigned tcnt;
   int unsigned last_start;
   int unsigned frame_ticks;
   logic [8:0]  cap;

   initial
   begin
      line_out = 1'b1;
      tcnt = 0;
      last_start = 0;
      frame_ticks = 0;
      cap = '0;
   end

   always @(posedge mclk)
      if (tick)
         tcnt <= tcnt + 1;

   // ****************************************
   // Receive: start edge to start edge gives frame length in ticks
   // ****************************************
   initial forever
   begin
      @(negedge line_in);
      frame_ticks = tcnt - last_start;
      last_start = tcnt;
      repeat (8) @(posedge mclk iff tick);
      for (int i = 0; i < nsamp; i++)
      begin
         repeat (16) @(posedge mclk iff tick);
         cap[i] = line_in;
      end
   end

   // ****************************************
   // Send: bit 0 first, sixteen ticks a bit, then back to mark
   // ****************************************
   task automatic send(input logic [11:0] f, input int n);
      for (int i = 0; i < n; i++)
      begin
         line_out <= f[i];
         repeat (16) @(posedge mclk iff tick);
      end
      line_out <= 1'b1;
   endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the line format and baud block
`timescale 1ns/1ps
module testbench;
   logic              mclk;
   logic              rstn;
   fmt_pkg::bus_req_t bus;
   logic [7:0]        rdata;
   logic              line_rx;
   logic              serial_output;
   logic              holding_empty_flag;
   logic              transmitter_idle_flag;
   logic              baud_tick;
   logic [3:0]        nsamp;
   logic [7:0]        v;
   logic [7:0]        w;
   int                n_mismatch;
   int                checked;
   int                seed;
   int                g1;
   int                g2;

   uart_line_ctrl u_dut (.mclk(mclk), .rstn(rstn), .bus(bus),
      .rdata(rdata), .serial_input(line_rx),
      .serial_output(serial_output),
      .holding_empty_flag(holding_empty_flag),
      .transmitter_idle_flag(transmitter_idle_flag),
      .baud_tick(baud_tick));
   serial_peer u_peer (.mclk(mclk), .tick(baud_tick),
      .line_in(serial_output), .nsamp(nsamp), .line_out(line_rx));

   always #2 mclk = ~mclk;

   // ****************************************
   // Reference model and bus tasks
   // ****************************************
   function automatic int exp_bits(input logic [7:0] l, input logic [7:0] d);
      int nb;
      int c;
      int r;
      nb = 5 + l[1:0];
      r = d & ((1 << nb) - 1);
      c = $countones(r);
      if (l[3])
         r = r | ((l[5] ? !l[4] : (l[4] ? c % 2 : 1 - c % 2)) << nb);
      return r;
   endfunction

   function automatic int frame_len(input logic [7:0] l);
      int nb;
      nb = 5 + l[1:0];
      return 16 * (1 + nb + l[3]) + (!l[2] ? 16 : (nb == 5 ? 24 : 32));
   endfunction

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus <= '{cs: 1'b1, wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      bus <= '0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk);
      bus <= '{cs: 1'b1, wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge mclk);
      bus <= '0;
      @(posedge mclk);
      #1 d = rdata;
   endtask

   task automatic wait_flag(input bit sel, input int lim);
      int k;
      k = 0;
      while ((sel ? transmitter_idle_flag : holding_empty_flag) !== 1'b1
             && k < lim)
      begin
         @(posedge mclk);
         #1 k++;
      end
      if (k >= lim)
      begin
         n_mismatch++;
         finish_test();
      end
   endtask

   task automatic tick_gap(output int a, output int b);
      a = 0;
      while (baud_tick !== 1'b1 && a < 300)
      begin
         @(posedge mclk);
         #1 a++;
      end
      b = 0;
      do
      begin
         @(posedge mclk);
         #1 b++;
      end while (baud_tick !== 1'b1 && b < 300);
   endtask

   task automatic tx_case(input logic [7:0] l);
      logic [7:0] d;
      int         n;
      int         fl;
      d = 8'($random(seed));
      n = 5 + l[1:0] + l[3];
      nsamp <= 4'(n);
      wr(fmt_pkg::OFS_LCR, l);
      wr(fmt_pkg::OFS_DATA, 8'h5A);
      #1 chk(16'(transmitter_idle_flag), 16'h0);
      wait_flag(1'b0, 50);
      wr(fmt_pkg::OFS_DATA, d);
      wait_flag(1'b1, 2000);
      fl = frame_len(l);
      g1 = u_peer.frame_ticks;
      chk(16'(g1 >= fl && g1 <= fl + 2), 16'h1);
      chk(16'(u_peer.cap & ((1 << n) - 1)), 16'(exp_bits(l, d)));
   endtask

   task automatic rx_case(input logic [7:0] l, input logic [7:0] d,
                          input bit flip, input bit stop);
      logic [11:0] f;
      int          n;
      n = 6 + l[1:0] + l[3];
      f = 12'(exp_bits(l, d) << 1);
      f[n] = stop;
      f[n - 1] = f[n - 1] ^ (flip & l[3]);
      wr(fmt_pkg::OFS_LCR, l);
      u_peer.send(f, n + 1);
      repeat (20) @(posedge mclk);
      rd(fmt_pkg::OFS_LSR, v);
      chk(16'(v), 16'(8'h61 | {4'h0, !stop, flip, 2'b00}));
      rd(fmt_pkg::OFS_DATA, v);
      chk(16'(v), 16'(d & ((1 << (5 + l[1:0])) - 1)));
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      mclk = 1'b0;
      rstn = 1'b0;
      bus = '0;
      nsamp = 4'h8;
      seed = 91295;
      n_mismatch = 0;
      checked = 0;
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      rd(fmt_pkg::OFS_LCR, v);
      chk(16'(v), 16'(fmt_pkg::LCR_RESET));
      rd(fmt_pkg::OFS_LSR, v);
      chk(16'(v), 16'h60);
      for (int i = 0; i < 6; i++)
      begin
         w = 8'($random(seed)) & 8'hBF;
         wr(fmt_pkg::OFS_LCR, w);
         rd(fmt_pkg::OFS_LCR, v);
         chk(16'(v), 16'(w));
      end
      wr(fmt_pkg::OFS_LCR, 8'h80);
      wr(fmt_pkg::OFS_DLM, 8'h00);
      wr(fmt_pkg::OFS_DLL, 8'h03);
      tick_gap(g1, g2);
      chk(16'(g2), 16'h3);
      wr(fmt_pkg::OFS_DLM, 8'hFF);
      rd(fmt_pkg::OFS_DLM, v);
      chk(16'(v), 16'hFF);
      wr(fmt_pkg::OFS_DLM, 8'h00);
      tick_gap(g1, g2);
      chk(16'(g1 <= 4), 16'h1);
      wr(fmt_pkg::OFS_DLL, 8'h02);
      tick_gap(g1, g2);
      chk(16'(g2), 16'h2);
      wr(fmt_pkg::OFS_LCR, 8'h00);
      wr(fmt_pkg::OFS_IER, 8'h05);
      rd(fmt_pkg::OFS_IER, v);
      chk(16'(v), 16'h05);
      rd(fmt_pkg::OFS_DATA, v);
      chk(16'(v), 16'h00);
      wr(fmt_pkg::OFS_LCR, 8'h80);
      rd(fmt_pkg::OFS_DLL, v);
      chk(16'(v), 16'h02);
      $display("done: registers and baud");
      for (int i = 0; i < 64; i++)
         tx_case(8'(i));
      $display("done: transmit formats");
      wr(fmt_pkg::OFS_LCR, 8'h03);
      wr(fmt_pkg::OFS_DATA, 8'h00);
      wait_flag(1'b0, 50);
      wr(fmt_pkg::OFS_LCR, 8'h43);
      wr(fmt_pkg::OFS_DATA, 8'hFF);
      g1 = 0;
      repeat (2) @(posedge mclk);
      repeat (400)
      begin
         @(posedge mclk);
         if (serial_output !== 1'b0)
            g1++;
      end
      chk(16'(g1), 16'h0);
      wait_flag(1'b1, 2000);
      wr(fmt_pkg::OFS_LCR, 8'h03);
      repeat (3) @(posedge mclk);
      chk(16'(serial_output), 16'h1);
      $display("done: break");
      rx_case(8'h1F, 8'hA5, 1'b0, 1'b1);
      rx_case(8'h0A, 8'h35, 1'b1, 1'b1);
      rx_case(8'h3B, 8'h81, 1'b0, 1'b1);
      rx_case(8'h2B, 8'h7E, 1'b0, 1'b1);
      rx_case(8'h00, 8'h15, 1'b0, 1'b0);
      $display("done: receive");
      finish_test();
   end

   initial
   begin
      repeat (100000) @(posedge mclk);
      n_mismatch++;
      finish_test();
   end
endmodule
